// ---- src/gfs_supervisor.sv ----
`timescale 1ns/1ps
module gfs_supervisor #(
  parameter logic [63:0] DAY_CYCLES    = gfs_pkg::DAY_CYCLES,
  parameter logic [63:0] SCROLL_CYCLES = gfs_pkg::SCROLL_CYCLES,
  parameter logic [63:0] STEP_CYCLES   = gfs_pkg::STEP_CYCLES,
  parameter logic [15:0] SENSOR_MIN    = 16'h0100,
  parameter logic [15:0] SENSOR_MAX    = 16'hF000
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic signed [15:0]  reading,
  input  wire logic [15:0]         full_scale,
  input  wire logic [15:0]         sensor_signal,
  input  wire logic [15:0]         supply_mv,
  input  wire logic signed [7:0]   temp_c,
  input  wire logic                zero_calibration_busy,
  input  wire logic                span_calibration_busy,
  input  wire logic                zero_calibration_ok,
  input  wire logic                span_calibration_ok,
  input  wire logic                span_range_fail,
  input  wire logic                span_stability_fail,
  input  wire logic                span_clearing_fail,
  input  wire logic [6:0]          life_estimate,
  input  wire logic                runtime_error,
  input  wire logic                nv_save_fail,
  input  wire logic                nv_save_ok,
  input  wire logic                loop_broken,
  input  wire logic                magnet_switch_down,
  input  wire logic                magnet_switch_up,
  output logic [15:0]              status_word,
  output logic [1:0]               loop_code,
  output logic [15:0]              disp_value,
  output logic                     disp_flash,
  output logic                     disp_negative,
  output logic                     disp_asterisk,
  output logic [6:0]               sensor_life,
  output logic [15:0]              days_since_span,
  output logic                     fault_msg_pulse,
  output logic                     show_fault_valid,
  output logic [3:0]               show_fault_index
);
  // Measurement decode
  wire        is_neg      = reading < 16'sd0;
  wire [15:0] mag         = is_neg ? 16'(-reading) : 16'(reading);
  wire [31:0] mag_x100    = 32'(mag) * 32'd100;
  wire [31:0] fs_x_min    = 32'(full_scale) * 32'(gfs_pkg::NEG_MIN_PCT);
  wire [31:0] fs_x_max    = 32'(full_scale) * 32'(gfs_pkg::NEG_MAX_PCT);
  wire [31:0] fs_x_zero   = 32'(full_scale) * 32'(gfs_pkg::ZERO_FAULT_PCT);
  wire        over_range  = !is_neg && (mag > full_scale);
  wire        neg_shown   = is_neg && (mag_x100 >= fs_x_min);
  wire        neg_clamped = is_neg && (mag_x100 > fs_x_max);
  wire [15:0] neg_limit   = 16'(fs_x_max / 32'd100);
  wire        zero_low    = is_neg && (mag_x100 > fs_x_zero);
  wire        in_cal      = zero_calibration_busy || span_calibration_busy;

  // Condition decode
  wire sensor_bad = (sensor_signal < SENSOR_MIN) || (sensor_signal > SENSOR_MAX);
  wire volt_bad   = (supply_mv < gfs_pkg::SUPPLY_MIN_MV) || (supply_mv > gfs_pkg::SUPPLY_MAX_MV);
  wire temp_bad   = (temp_c < gfs_pkg::TEMP_MIN_C) || (temp_c > gfs_pkg::TEMP_MAX_C);
  wire remind_due = days_since_span >= gfs_pkg::REMIND_DAYS;

  // Latched faults
  logic zero_reg, range_reg, stab_reg, clear_reg, mem_reg;
  logic zero_next, range_next, stab_next, clear_next, mem_next;
  assign zero_next  = zero_low || (zero_reg && !zero_calibration_ok);
  assign range_next = span_range_fail || (range_reg && !span_calibration_ok);
  assign stab_next  = span_stability_fail || (stab_reg && !span_calibration_ok);
  assign clear_next = span_clearing_fail || (clear_reg && !span_calibration_ok);
  assign mem_next   = nv_save_fail || (mem_reg && !nv_save_ok);

  // Status word assembly
  logic [15:0] faults;
  always_comb begin
    faults = 16'h0000;
    faults[gfs_pkg::SPAN_BIT]   = remind_due;
    faults[gfs_pkg::TEMP_BIT]   = temp_bad;
    faults[gfs_pkg::LOOP_BIT]   = loop_broken;
    faults[gfs_pkg::VOLT_BIT]   = volt_bad;
    faults[gfs_pkg::MEM_BIT]    = mem_reg;
    faults[gfs_pkg::PROC_BIT]   = runtime_error;
    faults[gfs_pkg::CLEAR_BIT]  = clear_reg;
    faults[gfs_pkg::STAB_BIT]   = stab_reg;
    faults[gfs_pkg::RANGE_BIT]  = range_reg;
    faults[gfs_pkg::SENSOR_BIT] = sensor_bad;
    faults[gfs_pkg::ZERO_BIT]   = zero_reg;
  end
  wire any_fault = |(faults & gfs_pkg::FAULT_MASK);
  wire kill_loop = |(faults & gfs_pkg::LOOP_KILL_MASK);
  logic [15:0] status_next;
  always_comb begin
    status_next = faults;
    status_next[gfs_pkg::GLOBAL_BIT] = any_fault;
    status_next[gfs_pkg::IN_CAL_BIT] = in_cal;
  end

  // Loop output selection
  gfs_pkg::gfs_loop_type loop_sel;
  assign loop_sel = kill_loop  ? gfs_pkg::LOOP_FAULT :
                    in_cal     ? gfs_pkg::LOOP_CAL :
                    over_range ? gfs_pkg::LOOP_OVER_RANGE :
                                 gfs_pkg::LOOP_NORMAL;

  // Display selection
  wire [15:0] disp_next = over_range  ? gfs_pkg::OVER_FS_VALUE :
                          neg_clamped ? neg_limit :
                          neg_shown   ? mag :
                          is_neg      ? 16'h0000 : mag;
  wire asterisk_next = neg_shown && (full_scale < gfs_pkg::SMALL_FS_PPM);

  // Sensor life
  wire [6:0] life_next = span_calibration_ok
                       ? ((life_estimate > gfs_pkg::LIFE_MAX) ? gfs_pkg::LIFE_MAX
                                                              : life_estimate)
                       : sensor_life;

  // Day counting
  logic day_tick;
  gfs_tick #(
    .WIDTH  (64),
    .PERIOD (DAY_CYCLES)
  ) u_day (
    .clock (clock),
    .rst_n (rst_n),
    .run   (!span_calibration_ok),
    .tick  (day_tick)
  );
  wire [15:0] days_next = span_calibration_ok ? gfs_pkg::DAYS_RESET :
                          (day_tick && days_since_span != 16'hFFFF)
                          ? days_since_span + 16'h0001 : days_since_span;

  // Fault message scrolling
  wire listing = show_fault_valid;
  logic scroll_tick;
  gfs_tick #(
    .WIDTH  (64),
    .PERIOD (SCROLL_CYCLES)
  ) u_scroll (
    .clock (clock),
    .rst_n (rst_n),
    .run   (any_fault && !in_cal && !listing),
    .tick  (scroll_tick)
  );

  // Fault listing on magnet swipe
  logic        mag_prev_reg;
  logic [15:0] pend_reg;
  logic [15:0] pend_next;
  logic        step_tick;
  wire magnet     = magnet_switch_down || magnet_switch_up;
  wire swipe      = magnet && !mag_prev_reg;
  wire msg_active = any_fault && !in_cal;
  wire start_list = swipe && msg_active && !listing;

  gfs_tick #(
    .WIDTH  (64),
    .PERIOD (STEP_CYCLES)
  ) u_step (
    .clock (clock),
    .rst_n (rst_n),
    .run   (listing),
    .tick  (step_tick)
  );

  function automatic logic [3:0] low_index(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : low_index

  wire [15:0] pend_src  = start_list ? (faults & gfs_pkg::FAULT_MASK) : pend_reg;
  wire        advance   = start_list || (listing && step_tick);
  wire [3:0]  next_idx  = low_index(pend_src);
  wire        have_next = |pend_src;
  assign pend_next = advance ? (pend_src & ~(16'h0001 << next_idx)) : pend_reg;
  wire        valid_next = advance ? have_next : show_fault_valid;
  wire [3:0]  index_next = (advance && have_next) ? next_idx : show_fault_index;

  // Latched fault flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      zero_reg  <= 1'b0;
      range_reg <= 1'b0;
      stab_reg  <= 1'b0;
      clear_reg <= 1'b0;
      mem_reg   <= 1'b0;
    end else begin
      zero_reg  <= zero_next;
      range_reg <= range_next;
      stab_reg  <= stab_next;
      clear_reg <= clear_next;
      mem_reg   <= mem_next;
    end
  end

  // Status word and loop code
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_word <= gfs_pkg::STATUS_RESET;
      loop_code   <= 2'(gfs_pkg::LOOP_NORMAL);
    end else begin
      status_word <= status_next;
      loop_code   <= 2'(loop_sel);
    end
  end

  // Display outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      disp_value    <= 16'h0000;
      disp_flash    <= 1'b0;
      disp_negative <= 1'b0;
      disp_asterisk <= 1'b0;
    end else begin
      disp_value    <= disp_next;
      disp_flash    <= over_range;
      disp_negative <= neg_shown && !over_range;
      disp_asterisk <= asterisk_next;
    end
  end

  // Sensor life and day count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sensor_life     <= gfs_pkg::LIFE_RESET;
      days_since_span <= gfs_pkg::DAYS_RESET;
    end else begin
      sensor_life     <= life_next;
      days_since_span <= days_next;
    end
  end

  // Scroll pulse and fault listing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_msg_pulse  <= 1'b0;
      mag_prev_reg     <= 1'b0;
      pend_reg         <= 16'h0000;
      show_fault_valid <= 1'b0;
      show_fault_index <= 4'h0;
    end else begin
      fault_msg_pulse  <= scroll_tick;
      mag_prev_reg     <= magnet;
      pend_reg         <= pend_next;
      show_fault_valid <= valid_next;
      show_fault_index <= index_next;
    end
  end
endmodule : gfs_supervisor

// ---- src/gfs_pkg.sv ----
package gfs_pkg;
  // Clock
  localparam longint unsigned CLK_HZ          = 64'd100_000_000;
  // Scroll period of the fault message, seconds
  localparam longint unsigned SCROLL_S        = 64'd30;
  localparam longint unsigned SCROLL_CYCLES   = SCROLL_S * CLK_HZ;
  // Length of one day, seconds
  localparam longint unsigned DAY_S           = 64'd86400;
  localparam longint unsigned DAY_CYCLES      = DAY_S * CLK_HZ;
  // Dwell per fault while faults are listed, seconds
  localparam longint unsigned STEP_S          = 64'd2;
  localparam longint unsigned STEP_CYCLES     = STEP_S * CLK_HZ;

  // Fault status word bit positions
  localparam int GLOBAL_BIT    = 0;
  localparam int SPAN_BIT      = 1;
  localparam int TEMP_BIT      = 2;
  localparam int LOOP_BIT      = 3;
  localparam int VOLT_BIT      = 4;
  localparam int MEM_BIT       = 5;
  localparam int PROC_BIT      = 6;
  localparam int CLEAR_BIT     = 7;
  localparam int STAB_BIT      = 8;
  localparam int RANGE_BIT     = 9;
  localparam int SENSOR_BIT    = 10;
  localparam int ZERO_BIT      = 11;
  localparam int IN_CAL_BIT    = 14;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  // Faults that drop the loop to the fault level
  localparam logic [15:0] LOOP_KILL_MASK  = 16'h0FF8;
  // Individual fault bits (global and in-calibration excluded)
  localparam logic [15:0] FAULT_MASK      = 16'h0FFE;

  // Thresholds
  localparam logic [15:0] OVER_FS_VALUE   = 16'h0064;
  localparam logic [15:0] NEG_MIN_PCT     = 16'h0005;
  localparam logic [15:0] NEG_MAX_PCT     = 16'h000A;
  localparam logic [15:0] ZERO_FAULT_PCT  = 16'h000A;
  localparam logic [15:0] SMALL_FS_PPM    = 16'h000A;
  localparam logic [15:0] SUPPLY_MIN_MV   = 16'h2CEC;
  localparam logic [15:0] SUPPLY_MAX_MV   = 16'h6D60;
  localparam logic signed [7:0] TEMP_MIN_C = -8'sd40;
  localparam logic signed [7:0] TEMP_MAX_C = 8'sd75;
  localparam logic [15:0] REMIND_DAYS     = 16'h00B4;
  localparam logic [6:0]  LIFE_MAX        = 7'h64;
  localparam logic [6:0]  LIFE_RESET      = 7'h64;
  localparam logic [15:0] DAYS_RESET      = 16'h0000;

  typedef enum {
    LOOP_NORMAL,
    LOOP_OVER_RANGE,
    LOOP_CAL,
    LOOP_FAULT
  } gfs_loop_type;
endpackage : gfs_pkg

// ---- src/gfs_tick.sv ----
`timescale 1ns/1ps
module gfs_tick #(
  parameter int              WIDTH  = 64,
  parameter logic [63:0]     PERIOD = 64'h0000_0000_0000_0010
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire              at_end = (count_reg == WIDTH'(PERIOD - 64'd1));

  // Restarts from zero whenever run drops
  assign count_next = (!run || at_end) ? '0 : count_reg + WIDTH'(1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick      <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick      <= run && at_end;
    end
  end
endmodule : gfs_tick

// ---- sim/gfs_checker.sv ----
`timescale 1ns/1ps
module gfs_checker (
  input wire logic               clock,
  input wire logic               rst_n,
  input wire logic signed [15:0] reading,
  input wire logic [15:0]        full_scale,
  input wire logic signed [7:0]  temp_c,
  input wire logic               zero_calibration_busy,
  input wire logic               span_calibration_busy,
  input wire logic               span_range_fail,
  input wire logic               runtime_error,
  input wire logic [15:0]        status_word,
  input wire logic [1:0]         loop_code,
  input wire logic [15:0]        disp_value,
  input wire logic               disp_flash,
  input wire logic               fault_msg_pulse
);
  // High once the previous edge was out of reset
  logic up;
  wire  cal  = zero_calibration_busy | span_calibration_busy;
  wire  over = reading > $signed({1'h0, full_scale});
  always_ff @(posedge clock) begin
    up <= rst_n;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  cal_loop_a: assert property (up && cal |=> status_word[14] && loop_code[1])
    else $error("calibration not flagged on loop or status");
  over_range_a: assert property (up && over && !cal |=> disp_flash &&
    disp_value == 16'h0064)
    else $error("over-range display wrong");
  global_bit_a: assert property (status_word[0] == |(status_word & gfs_pkg::FAULT_MASK))
    else $error("global bit disagrees with fault bits");
  kill_loop_a: assert property (|(status_word & gfs_pkg::LOOP_KILL_MASK) |->
    loop_code == 2'h3)
    else $error("loop not at fault level");
  mild_loop_a: assert property (status_word[15:3] == 13'h0000 |-> loop_code != 2'h3)
    else $error("loop at fault level without cause");
  temp_live_a: assert property (up |=>
    status_word[2] == ($past(temp_c) < 8'shD8 || $past(temp_c) > 8'sh4B))
    else $error("temperature bit wrong");
  proc_live_a: assert property (up |=> status_word[6] == $past(runtime_error))
    else $error("processor bit wrong");
  range_set_a: assert property (up && span_range_fail |=> ##1 status_word[9])
    else $error("range bit not set");
  scroll_gap_a: assert property (fault_msg_pulse |=> !fault_msg_pulse [*8])
    else $error("scroll pulses too close");
  cover property (up && over);
  cover property (up && cal);
  cover property (fault_msg_pulse);
  cover property (up && |(status_word & gfs_pkg::LOOP_KILL_MASK));
endmodule : gfs_checker

bind gfs_supervisor gfs_checker u_chk (
  .clock                 (clock),
  .rst_n                 (rst_n),
  .reading               (reading),
  .full_scale            (full_scale),
  .temp_c                (temp_c),
  .zero_calibration_busy (zero_calibration_busy),
  .span_calibration_busy (span_calibration_busy),
  .span_range_fail       (span_range_fail),
  .runtime_error         (runtime_error),
  .status_word           (status_word),
  .loop_code             (loop_code),
  .disp_value            (disp_value),
  .disp_flash            (disp_flash),
  .fault_msg_pulse       (fault_msg_pulse)
);

// ---- sim/gfs_master.sv ----
`timescale 1ns/1ps
module gfs_master #(
  parameter int POLL = 8
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [15:0] status_word,
  output logic [15:0]     polled
);
  // Remote master reads the status word once per poll interval
  int cnt;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt <= 0;
      polled <= 16'h0000;
    end else if (cnt == POLL - 1) begin
      cnt <= 0;
      polled <= status_word;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : gfs_master

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
  // Pulse input selectors
  localparam int ZERO_OK   = 0;
  localparam int SPAN_OK   = 1;
  localparam int RANGE_ERR = 2;
  localparam int STAB_ERR  = 3;
  localparam int CLEAR_ERR = 4;
  localparam int SAVE_ERR  = 5;
  localparam int SAVE_OK   = 6;
  logic clock = 1'h0, rst_n = 1'h0;
  logic signed [15:0] reading = 16'sh0000;
  logic [15:0] full_scale = 16'h0064, sensor_signal = 16'h1000, supply_mv = 16'h5DC0;
  logic signed [7:0] temp_c = 8'sh19;
  logic zero_calibration_busy = 1'h0, span_calibration_busy = 1'h0;
  logic zero_calibration_ok = 1'h0, span_calibration_ok = 1'h0, span_range_fail = 1'h0;
  logic span_stability_fail = 1'h0, span_clearing_fail = 1'h0, runtime_error = 1'h0;
  logic nv_save_fail = 1'h0, nv_save_ok = 1'h0, loop_broken = 1'h0;
  logic magnet_switch_down = 1'h0, magnet_switch_up = 1'h0;
  logic [6:0] life_estimate = 7'h00, sensor_life;
  logic [15:0] status_word, disp_value, days_since_span, polled;
  logic [1:0] loop_code;
  logic disp_flash, disp_negative, disp_asterisk, fault_msg_pulse, show_fault_valid;
  logic [3:0] show_fault_index;
  int error_cnt = 0, n_checks = 0;
  always #5 clock = ~clock;
  gfs_supervisor #(.DAY_CYCLES(64'h32), .SCROLL_CYCLES(64'h14), .STEP_CYCLES(64'h5)) DUT (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .reading               (reading),
    .full_scale            (full_scale),
    .sensor_signal         (sensor_signal),
    .supply_mv             (supply_mv),
    .temp_c                (temp_c),
    .zero_calibration_busy (zero_calibration_busy),
    .span_calibration_busy (span_calibration_busy),
    .zero_calibration_ok   (zero_calibration_ok),
    .span_calibration_ok   (span_calibration_ok),
    .span_range_fail       (span_range_fail),
    .span_stability_fail   (span_stability_fail),
    .span_clearing_fail    (span_clearing_fail),
    .life_estimate         (life_estimate),
    .runtime_error         (runtime_error),
    .nv_save_fail          (nv_save_fail),
    .nv_save_ok            (nv_save_ok),
    .loop_broken           (loop_broken),
    .magnet_switch_down    (magnet_switch_down),
    .magnet_switch_up      (magnet_switch_up),
    .status_word           (status_word),
    .loop_code             (loop_code),
    .disp_value            (disp_value),
    .disp_flash            (disp_flash),
    .disp_negative         (disp_negative),
    .disp_asterisk         (disp_asterisk),
    .sensor_life           (sensor_life),
    .days_since_span       (days_since_span),
    .fault_msg_pulse       (fault_msg_pulse),
    .show_fault_valid      (show_fault_valid),
    .show_fault_index      (show_fault_index)
  );
  gfs_master u_master (.clock(clock), .rst_n(rst_n), .status_word(status_word), .polled(polled));
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Flag watched by wait_hi: 0 scroll pulse, otherwise listing valid
  function automatic logic flag(input int sel);
    return (sel == 0) ? fault_msg_pulse : show_fault_valid;
  endfunction : flag
  task automatic wait_hi(input int sel, input int lim);
    int i = 0;
    while (flag(sel) !== 1'h1 && i < lim) begin
      step(1);
      i++;
    end
    if (flag(sel) !== 1'h1) begin
      error_cnt++;
      final_report();
    end
  endtask : wait_hi
  task automatic set_pulse(input int k, input logic v);
    case (k)
      ZERO_OK:   zero_calibration_ok = v;
      SPAN_OK:   span_calibration_ok = v;
      RANGE_ERR: span_range_fail = v;
      STAB_ERR:  span_stability_fail = v;
      CLEAR_ERR: span_clearing_fail = v;
      SAVE_ERR:  nv_save_fail = v;
      default:   nv_save_ok = v;
    endcase
  endtask : set_pulse
  task automatic pulse(input int k);
    set_pulse(k, 1'h1);
    step(1);
    set_pulse(k, 1'h0);
  endtask : pulse
  task automatic set_live(input int k, input logic v);
    case (k)
      0: temp_c = v ? 8'sh4C : 8'sh19;
      1: supply_mv = v ? 16'h2CEB : 16'h5DC0;
      2: runtime_error = v;
      3: loop_broken = v;
      default: sensor_signal = v ? 16'h00FF : 16'h1000;
    endcase
  endtask : set_live
  task automatic t_disp();
    reading = 16'sh0078;
    step(2);
    `CHK(disp_flash, 1'h1)
    `CHK(disp_value, 16'h0064)
    `CHK(loop_code, 2'h1)
    reading = -16'sh0006;
    step(2);
    `CHK(disp_negative, 1'h1)
    `CHK(disp_value, 16'h0006)
    reading = -16'sh0003;
    step(2);
    `CHK(disp_negative, 1'h0)
    full_scale = 16'h0005;
    reading = -16'sh0001;
    step(3);
    `CHK(disp_asterisk, 1'h1)
    `CHK(status_word, 16'h0801)
    full_scale = 16'h0064;
    reading = 16'sh0000;
    step(3);
    `CHK(status_word[11], 1'h1)
    pulse(ZERO_OK);
    step(2);
    `CHK(status_word, 16'h0000)
  endtask : t_disp
  task automatic t_cal();
    reading = 16'sh0078;
    zero_calibration_busy = 1'h1;
    step(2);
    `CHK(loop_code, 2'h2)
    `CHK(status_word, 16'h4000)
    runtime_error = 1'h1;
    step(2);
    `CHK(loop_code, 2'h3)
    zero_calibration_busy = 1'h0;
    span_calibration_busy = 1'h1;
    runtime_error = 1'h0;
    reading = 16'sh0000;
    step(2);
    `CHK(status_word, 16'h4000)
    span_calibration_busy = 1'h0;
    step(2);
  endtask : t_cal
  task automatic t_faults();
    logic [15:0] m [5] = '{16'h0004, 16'h0010, 16'h0040, 16'h0008, 16'h0400};
    for (int k = 0; k < 5; k++) begin
      set_live(k, 1'h1);
      step(2);
      `CHK(status_word, m[k] | 16'h0001)
      `CHK(loop_code, (k == 0) ? 2'h0 : 2'h3)
      set_live(k, 1'h0);
      step(2);
      `CHK(status_word, 16'h0000)
    end
    for (int k = 0; k < 3; k++) begin
      if (k == 0) pulse(RANGE_ERR);
      else if (k == 1) pulse(STAB_ERR);
      else pulse(CLEAR_ERR);
      step(3);
      `CHK(status_word, (16'h0200 >> k) | 16'h0001)
      life_estimate = 7'(7'h4B - k);
      pulse(SPAN_OK);
      step(2);
      `CHK(status_word, 16'h0000)
      `CHK(sensor_life, 7'(7'h4B - k))
    end
    pulse(SAVE_ERR);
    step(3);
    `CHK(status_word, 16'h0021)
    pulse(SAVE_OK);
    step(2);
    `CHK(status_word, 16'h0000)
  endtask : t_faults
  task automatic t_list();
    runtime_error = 1'h1;
    loop_broken = 1'h1;
    wait_hi(0, 30);
    step(19);
    `CHK(fault_msg_pulse, 1'h0)
    step(1);
    `CHK(fault_msg_pulse, 1'h1)
    magnet_switch_down = 1'h1;
    wait_hi(1, 5);
    `CHK(show_fault_index, 4'h3)
    step(6);
    `CHK(show_fault_index, 4'h6)
    step(6);
    `CHK(show_fault_valid, 1'h0)
    magnet_switch_down = 1'h0;
    step(1);
    magnet_switch_up = 1'h1;
    wait_hi(1, 5);
    `CHK(show_fault_index, 4'h3)
    magnet_switch_up = 1'h0;
    runtime_error = 1'h0;
    loop_broken = 1'h0;
    step(14);
    `CHK(show_fault_valid, 1'h0)
  endtask : t_list
  task automatic t_days();
    pulse(SPAN_OK);
    step(160);
    `CHK(days_since_span, 16'h0003)
    step(8780);
    `CHK(status_word[1], 1'h0)
    step(70);
    `CHK(status_word, 16'h0003)
    `CHK(loop_code, 2'h0)
    `CHK(polled, 16'h0003)
  endtask : t_days
  task automatic t_reset();
    rst_n = 1'h0;
    step(2);
    `CHK(status_word, 16'h0000)
    `CHK(days_since_span, 16'h0000)
    `CHK(sensor_life, 7'h64)
    rst_n = 1'h1;
    step(2);
    `CHK(status_word, 16'h0000)
    `CHK(loop_code, 2'h0)
  endtask : t_reset
  initial begin
    step(5);
    `CHK(status_word, 16'h0000)
    `CHK(sensor_life, 7'h64)
    rst_n = 1'h1;
    step(2);
    t_disp();
    t_cal();
    t_faults();
    t_list();
    t_days();
    t_reset();
    final_report();
  end
endmodule : testbench
